/* verilog/quadrature_position_counter.sv */
// Quadrature encoder position counter with an APB register slave.
// Assumes a single clock, an APB master in the same domain and an
// incremental encoder on the phase and index pins.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`include "qpc_cfg.svh"

////////////////////////////////////////////////////////////////////////////
module quadrature_position_counter
  import qpc_pkg::*;
#(
  parameter int CNT_W = `QPC_CNT_W
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ce_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [`QPC_ADDR_W-1:0] paddr_i,
  input  wire logic [`QPC_DATA_W-1:0] pwdata_i,
  input  wire logic                   phase_a_in_i,
  input  wire logic                   phase_b_in_i,
  input  wire logic                   index_in_i,
  output logic      [`QPC_DATA_W-1:0] prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  output logic                        irq_o,
  output logic                        count_direction_o
);

  if (CNT_W > `QPC_DATA_W) begin : g_too_wide
    $error("Count width must fit the data bus.");
  end
  if (CNT_W != `QPC_CNT_W) begin : g_bad_cnt
    $error("Count width must match the 16-bit register layout.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Index reset modes are the only ones with error checking.
  function automatic logic is_idx_mode(input logic [2:0] m);
    return (m == `QPC_MODE_X2_IDX) || (m == `QPC_MODE_X4_IDX);
  endfunction

  // Codes 110 and 111 count both phases.
  function automatic logic is_x4_mode(input logic [2:0] m);
    return (m == `QPC_MODE_X4_IDX) || (m == `QPC_MODE_X4_MAX);
  endfunction

  // Addresses that hold a register.
  function automatic logic addr_hit(input logic [`QPC_ADDR_W-1:0] a);
    return (a == `QPC_OFF_CTRL) || (a == `QPC_OFF_FILT) ||
           (a == `QPC_OFF_POS) || (a == `QPC_OFF_MAX) ||
           (a == `QPC_OFF_ISTAT) || (a == `QPC_OFF_IMASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [2:0]             operating_mode_select;
  logic                   index_reset_enable;
  logic                   error_irq_disable;
  logic                   count_error_flag;
  logic                   count_direction;
  logic [CNT_W-1:0]       position_count;
  logic [CNT_W-1:0]       max_count_limit;
  logic [`QPC_IRQ_W-1:0]  irq_status;
  logic [`QPC_IRQ_W-1:0]  irq_mask;
  logic [`QPC_SYNC_W-1:0] pin_now;
  logic [`QPC_SYNC_W-1:0] pin_prev;
  logic [CNT_W-1:0]       next_position;
  logic [`QPC_IRQ_W-1:0]  next_irq_status;
  logic [`QPC_IRQ_W-1:0]  irq_event;
  logic [`QPC_IRQ_W-1:0]  irq_w1c;
  logic                   a_chg;
  logic                   b_chg;
  logic                   dir_up;
  logic                   count_pulse;
  logic                   idx_mode;
  logic                   index_rise;
  logic                   idx_clear;
  logic                   err_hit;
  logic                   wr_en;
  logic                   wr_ctrl;
  logic                   wr_pos;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and edge decode.

  // Phase and index pins are brought into the clock domain first.
  phase_sync #(
    .WIDTH (`QPC_SYNC_W)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .async_i ({index_in_i, phase_b_in_i, phase_a_in_i}),
    .sync_o  (pin_now),
    .prev_o  (pin_prev)
  );

  // A step is counted only when exactly one phase moved; a double change
  // is a lost step and is dropped rather than guessed.
  assign a_chg       = pin_now[`QPC_SYNC_A] ^ pin_prev[`QPC_SYNC_A];
  assign b_chg       = pin_now[`QPC_SYNC_B] ^ pin_prev[`QPC_SYNC_B];
  assign dir_up      = pin_now[`QPC_SYNC_A] ^ pin_prev[`QPC_SYNC_B];
  assign idx_mode    = is_idx_mode(operating_mode_select);
  assign count_pulse = operating_mode_select[2] &
                       (is_x4_mode(operating_mode_select) ?
                        (a_chg ^ b_chg) :
                        (a_chg & ~b_chg));
  assign index_rise  = pin_now[`QPC_SYNC_IDX] & ~pin_prev[`QPC_SYNC_IDX];

  // The index only counts as a reference while both phases are low.
  assign idx_clear = idx_mode & index_reset_enable & index_rise &
                     ~pin_now[`QPC_SYNC_A] &
                     ~pin_now[`QPC_SYNC_B];

  ////////////////////////////////////////////////////////////////////////////
  // Next position.

  // Index modes run free over the full range; max modes wrap at the limit.
  always_comb begin
    next_position = position_count;
    if (count_pulse) begin
      if (idx_mode) begin
        next_position = dir_up ? position_count + 1'b1
                               : position_count - 1'b1;
      end else if (dir_up) begin
        next_position = (position_count == max_count_limit) ?
                        '0 : position_count + 1'b1;
      end else begin
        next_position = (position_count == '0) ?
                        max_count_limit : position_count - 1'b1;
      end
    end
  end

  // Going up, reaching max plus one is an error; going down, all ones.
  assign err_hit = idx_mode & count_pulse & ~idx_clear &
                   (dir_up ? ({1'b0, next_position} ==
                              {1'b0, max_count_limit} + 1'b1)
                           : (next_position == {CNT_W{1'b1}}));

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // One access cycle per transfer: pready rises on the setup edge.
  assign wr_en   = psel_i & penable_i & pwrite_i & pready_o;
  assign wr_ctrl = wr_en & (paddr_i == `QPC_OFF_CTRL);
  assign wr_pos  = wr_en & (paddr_i == `QPC_OFF_POS);
  assign irq_w1c = (wr_en && paddr_i == `QPC_OFF_ISTAT) ?
                   pwdata_i[`QPC_IRQ_W-1:0] : '0;

  // Setup cycle latches the answer so all bus outputs are registered.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else if (ce_i) begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_hit(paddr_i);
      prdata_o  <= '0;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (paddr_i)
          `QPC_OFF_CTRL: begin
            prdata_o[`QPC_CTRL_ERR]   <= count_error_flag;
            prdata_o[`QPC_CTRL_DIR]   <= count_direction;
            prdata_o[`QPC_CTRL_MODE_H:`QPC_CTRL_MODE_L]
                                      <= operating_mode_select;
            prdata_o[`QPC_CTRL_IDXEN] <= index_reset_enable;
          end
          `QPC_OFF_FILT: begin
            prdata_o[`QPC_FILT_ERROR_IRQ_DISABLE] <= error_irq_disable;
          end
          `QPC_OFF_POS: begin
            prdata_o[CNT_W-1:0] <= position_count;
          end
          `QPC_OFF_MAX: begin
            prdata_o[CNT_W-1:0] <= max_count_limit;
          end
          `QPC_OFF_ISTAT: begin
            prdata_o[`QPC_IRQ_W-1:0] <= irq_status;
          end
          `QPC_OFF_IMASK: begin
            prdata_o[`QPC_IRQ_W-1:0] <= irq_mask;
          end
          default: begin
            prdata_o <= '0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register.

  // Mode and index enable are plain software fields.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      operating_mode_select <= `QPC_MODE_OFF;
      index_reset_enable    <= 1'b0;
    end else if (ce_i && wr_ctrl) begin
      operating_mode_select <=
        pwdata_i[`QPC_CTRL_MODE_H:`QPC_CTRL_MODE_L];
      index_reset_enable    <= pwdata_i[`QPC_CTRL_IDXEN];
    end
  end

  // Hardware never clears the error flag, and a new error wins over a
  // software write of zero in the same cycle.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_error_flag <= 1'b0;
    end else if (ce_i) begin
      if (err_hit) begin
        count_error_flag <= 1'b1;
      end else if (wr_ctrl) begin
        count_error_flag <= pwdata_i[`QPC_CTRL_ERR];
      end
    end
  end

  // Interrupt disable for the count error event.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      error_irq_disable <= 1'b0;
    end else if (ce_i && wr_en && paddr_i == `QPC_OFF_FILT) begin
      error_irq_disable <= pwdata_i[`QPC_FILT_ERROR_IRQ_DISABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position, limit and direction.

  // Index clear beats a software load, which beats a count step.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      position_count <= '0;
    end else if (ce_i) begin
      if (idx_clear) begin
        position_count <= '0;
      end else if (wr_pos) begin
        position_count <= pwdata_i[CNT_W-1:0];
      end else begin
        position_count <= next_position;
      end
    end
  end

  // The limit resets to all ones so max modes run the full range.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      max_count_limit <= `QPC_MAX_RST;
    end else if (ce_i && wr_en && paddr_i == `QPC_OFF_MAX) begin
      max_count_limit <= pwdata_i[CNT_W-1:0];
    end
  end

  // Direction holds its last decoded value between steps.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_direction <= 1'b0;
    end else if (ce_i && count_pulse) begin
      count_direction <= dir_up;
    end
  end

  assign count_direction_o = count_direction;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  // Wraps are deliberately absent from the event list.
  assign irq_event[`QPC_IRQ_ERR] = err_hit & ~error_irq_disable;
  assign irq_event[`QPC_IRQ_IDX] = idx_mode & index_rise;
  assign next_irq_status = (irq_status & ~irq_w1c) | irq_event;

  // Sticky status with write-one-to-clear; the set wins over the clear.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= '0;
    end else if (ce_i) begin
      irq_status <= next_irq_status;
    end
  end

  // Mask register of the same layout.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask <= '0;
    end else if (ce_i && wr_en && paddr_i == `QPC_OFF_IMASK) begin
      irq_mask <= pwdata_i[`QPC_IRQ_W-1:0];
    end
  end

  // Level output follows status and mask one edge later.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_DIR_DECODE: assert property (
    ce_i && count_pulse |=> count_direction == $past(dir_up))
    else $error("Direction does not follow the phase order.");

  AST_STEP_ONE: assert property (
    ce_i && count_pulse && idx_mode && !idx_clear && !wr_pos && dir_up
    |=> position_count == $past(position_count) + 1'b1)
    else $error("Position did not step up by one.");

  AST_MODE_FIELD: assert property (
    ce_i && wr_ctrl |=> operating_mode_select ==
      $past(pwdata_i[`QPC_CTRL_MODE_H:`QPC_CTRL_MODE_L]))
    else $error("Mode field not taken from control bits.");

  AST_ERR_ONLY_IDX: assert property (
    $rose(count_error_flag) && !$past(wr_ctrl && pwdata_i[`QPC_CTRL_ERR])
    |-> $past(idx_mode))
    else $error("Count error raised outside index modes.");

  AST_ERR_SETS: assert property (
    ce_i && err_hit && !error_irq_disable
    |=> count_error_flag && irq_status[`QPC_IRQ_ERR])
    else $error("Count error did not set flag and status.");

  AST_ERROR_IRQ_DISABLE_BLOCK: assert property (
    ce_i && err_hit && error_irq_disable && !irq_status[`QPC_IRQ_ERR]
    |=> count_error_flag && !irq_status[`QPC_IRQ_ERR])
    else $error("Disabled error interrupt still set status.");

  AST_COUNT_ON: assert property (
    ce_i && err_hit && !wr_pos
    |=> position_count != $past(position_count))
    else $error("Counting stopped after a count error.");

  AST_WRAP_QUIET: assert property (
    ce_i && idx_mode && count_pulse && dir_up && !idx_clear && !wr_pos &&
    position_count == {CNT_W{1'b1}} && max_count_limit != {CNT_W{1'b1}}
    |=> position_count == '0 && !$rose(irq_status[`QPC_IRQ_ERR]))
    else $error("Natural rollover misbehaved or interrupted.");

  AST_FLAG_STICKY: assert property (
    count_error_flag && !(ce_i && wr_ctrl && !pwdata_i[`QPC_CTRL_ERR])
    |=> count_error_flag)
    else $error("Error flag cleared without a software write.");

  AST_X2_IGNORES_B: assert property (
    ce_i && operating_mode_select[2] && !operating_mode_select[1] &&
    !a_chg && !idx_clear && !wr_pos |=> $stable(position_count))
    else $error("Double rate mode counted a phase B edge.");

  AST_X4_B_COUNTS: assert property (
    ce_i && is_x4_mode(operating_mode_select) && b_chg && !a_chg &&
    max_count_limit != '0 &&
    !idx_clear && !wr_pos |=> position_count != $past(position_count))
    else $error("Quad rate mode missed a phase B edge.");

  AST_IDX_CLEAR: assert property (
    ce_i && idx_clear |=> position_count == '0)
    else $error("Index pulse did not clear the position.");

  AST_DIR_READ: assert property (
    ce_i && psel_i && !penable_i && !pwrite_i && paddr_i == `QPC_OFF_CTRL
    |=> prdata_o[`QPC_CTRL_DIR] == $past(count_direction))
    else $error("Direction bit reads back wrong.");

  COV_X4_UP: cover property (
    ce_i && is_x4_mode(operating_mode_select) && count_pulse && dir_up);
  COV_ERR: cover property (ce_i && err_hit);
  COV_IDX: cover property (ce_i && idx_clear);
  COV_IRQ: cover property ($rose(irq_o));

endmodule

/* verilog/qpc_cfg.svh */
// Constants of the quadrature position counter: offsets, fields, codes.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef QPC_CFG_SVH
`define QPC_CFG_SVH

`define QPC_CNT_W       16
`define QPC_ADDR_W      8
`define QPC_DATA_W      32
`define QPC_SYNC_W      3
`define QPC_IRQ_W       2

`define QPC_OFF_CTRL    8'h00
`define QPC_OFF_FILT    8'h04
`define QPC_OFF_POS     8'h08
`define QPC_OFF_MAX     8'h0C
`define QPC_OFF_ISTAT   8'h10
`define QPC_OFF_IMASK   8'h14

`define QPC_CTRL_ERR    15
`define QPC_CTRL_DIR    11
`define QPC_CTRL_MODE_H 10
`define QPC_CTRL_MODE_L 8
`define QPC_CTRL_IDXEN  2
`define QPC_FILT_ERROR_IRQ_DISABLE   8
`define QPC_IRQ_ERR     0
`define QPC_IRQ_IDX     1

`define QPC_MODE_OFF    3'h0
`define QPC_MODE_X2_IDX 3'h4
`define QPC_MODE_X2_MAX 3'h5
`define QPC_MODE_X4_IDX 3'h6
`define QPC_MODE_X4_MAX 3'h7

`define QPC_MAX_RST     16'hFFFF
`define QPC_SYNC_A      0
`define QPC_SYNC_B      1
`define QPC_SYNC_IDX    2

`endif

/* verilog/qpc_pkg.sv */
// Types shared by the quadrature position counter files.
// Assumes qpc_cfg.svh is on the include path.
`include "qpc_cfg.svh"

package qpc_pkg;

  // Operating mode codes of the mode field.
  typedef enum logic [2:0] {
    MODE_OFF    = `QPC_MODE_OFF,
    MODE_X2_IDX = `QPC_MODE_X2_IDX,
    MODE_X2_MAX = `QPC_MODE_X2_MAX,
    MODE_X4_IDX = `QPC_MODE_X4_IDX,
    MODE_X4_MAX = `QPC_MODE_X4_MAX
  } mode_e;

  typedef logic [`QPC_DATA_W-1:0] word_t;

endpackage

/* verilog/phase_sync.sv */
// Two-flop synchroniser with a history stage for edge detection.
// Assumes inputs may change at any time relative to mclk_i.
`timescale 1ns/100ps

module phase_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o,
  output logic      [WIDTH-1:0] prev_o
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("phase_sync needs at least one bit.");
  end

  // Only the second stage reads the first, so metastability stays contained.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= '0;
      sync_o <= '0;
      prev_o <= '0;
    end else if (ce_i) begin
      meta   <= async_i;
      sync_o <= meta;
      prev_o <= sync_o;
    end
  end

endmodule

/* tb/qpc_encoder_model.sv */
// Behavioural incremental encoder that drives the phase and index pins.
// Assumes the caller runs its tasks from the bench clock.
`timescale 1ns/100ps

module qpc_encoder_model (
  input  wire logic clk_i,
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  logic [1:0] st = 2'h0;

  // Forward runs AB 00,10,11,01 so that phase A leads phase B.
  assign phase_a_o = st[1] ^ st[0];
  assign phase_b_o = st[1];

  initial index_o = 1'b0;

  // Each level is held at least five edges, well above the two sampled cycles.
  task automatic step(input bit fwd);
    @(posedge clk_i);
    st <= fwd ? st + 2'h1 : st - 2'h1;
    repeat (4) @(posedge clk_i);
  endtask

  // Turn the shaft forward until both phases are low.
  task automatic home();
    while (st != 2'h0) step(1'b1);
  endtask

  // The index pulse only ever comes while both phases are low.
  task automatic pulse();
    @(posedge clk_i);
    index_o <= (st == 2'h0);
    repeat (4) @(posedge clk_i);
    index_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* tb/quadrature_position_counter_tb_top.sv */
// Self-checking bench for the quadrature position counter.
// Assumes the design files and the encoder model are compiled first.
`timescale 1ns/100ps
`include "qpc_cfg.svh"

module quadrature_position_counter_tb_top import qpc_pkg::*;;
  logic       clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic       irq, dir, pha, phb, idx, rerr, ce;
  logic [7:0] paddr;
  word_t      pwdata, prdata, rd;
  int         miscompares = 0;
  int         comparisons = 0;

  quadrature_position_counter uut (
    .mclk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .phase_a_in_i(pha), .phase_b_in_i(phb),
    .index_in_i(idx), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .count_direction_o(dir));

  qpc_encoder_model enc (
    .clk_i(clk), .phase_a_o(pha), .phase_b_o(phb), .index_o(idx));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison, bus and reporting tasks.
  task automatic chk_word(input word_t got, input word_t exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer; only the watchdog ends a wait that never sees ready.
  task automatic apb(input logic wr, input logic [7:0] a, input word_t d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input word_t d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input word_t exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    rd_chk(`QPC_OFF_CTRL, 32'h0);
    rd_chk(`QPC_OFF_POS, 32'h0);
    rd_chk(`QPC_OFF_MAX, 32'h0000FFFF);
    chk_bit(irq, 1'b0);
    wr(`QPC_OFF_IMASK, 32'h1);
    done("reset");
  endtask

  task automatic t_x4();
    wr(`QPC_OFF_CTRL, 32'h0600);
    repeat (4) enc.step(1'b1);
    rd_chk(`QPC_OFF_POS, 32'h4);
    rd_chk(`QPC_OFF_CTRL, 32'h0E00);
    chk_bit(dir, 1'b1);
    repeat (2) enc.step(1'b0);
    rd_chk(`QPC_OFF_POS, 32'h2);
    chk_bit(dir, 1'b0);
    done("x4");
  endtask

  // Four quarter steps carry exactly two phase A edges.
  task automatic t_x2();
    wr(`QPC_OFF_CTRL, 32'h0500);
    wr(`QPC_OFF_POS, 32'h0);
    repeat (4) enc.step(1'b1);
    rd_chk(`QPC_OFF_POS, 32'h2);
    done("x2");
  endtask

  task automatic t_err_up();
    wr(`QPC_OFF_CTRL, 32'h0600);
    wr(`QPC_OFF_MAX, 32'h3);
    wr(`QPC_OFF_POS, 32'h3);
    enc.step(1'b1);
    rd_chk(`QPC_OFF_CTRL, 32'h8E00);
    rd_chk(`QPC_OFF_ISTAT, 32'h1);
    chk_bit(irq, 1'b1);
    enc.step(1'b1);
    rd_chk(`QPC_OFF_POS, 32'h5);
    rd_chk(`QPC_OFF_CTRL, 32'h8E00);
    wr(`QPC_OFF_CTRL, 32'h0600);
    wr(`QPC_OFF_ISTAT, 32'h1);
    rd_chk(`QPC_OFF_CTRL, 32'h0E00);
    chk_bit(irq, 1'b0);
    done("error up");
  endtask

  task automatic t_error_irq_disable();
    wr(`QPC_OFF_FILT, 32'h0100);
    wr(`QPC_OFF_POS, 32'h3);
    enc.step(1'b1);
    rd_chk(`QPC_OFF_CTRL, 32'h8E00);
    rd_chk(`QPC_OFF_ISTAT, 32'h0);
    chk_bit(irq, 1'b0);
    wr(`QPC_OFF_FILT, 32'h0);
    done("error masked");
  endtask

  // Two reverse quarter steps hold exactly one phase A edge.
  task automatic t_err_dn();
    wr(`QPC_OFF_CTRL, 32'h0400);
    wr(`QPC_OFF_POS, 32'h0);
    repeat (2) enc.step(1'b0);
    rd_chk(`QPC_OFF_POS, 32'hFFFF);
    rd_chk(`QPC_OFF_CTRL, 32'h8400);
    rd_chk(`QPC_OFF_ISTAT, 32'h1);
    wr(`QPC_OFF_CTRL, 32'h0400);
    wr(`QPC_OFF_ISTAT, 32'h1);
    done("error down");
  endtask

  task automatic t_wrap();
    wr(`QPC_OFF_CTRL, 32'h0700);
    wr(`QPC_OFF_POS, 32'h3);
    enc.step(1'b1);
    rd_chk(`QPC_OFF_POS, 32'h0);
    enc.step(1'b0);
    rd_chk(`QPC_OFF_POS, 32'h3);
    rd_chk(`QPC_OFF_ISTAT, 32'h0);
    rd_chk(`QPC_OFF_CTRL, 32'h0700);
    chk_bit(irq, 1'b0);
    done("wrap");
  endtask

  task automatic t_index();
    enc.home();
    wr(`QPC_OFF_CTRL, 32'h0604);
    wr(`QPC_OFF_POS, 32'h7);
    enc.pulse();
    rd_chk(`QPC_OFF_POS, 32'h0);
    wr(`QPC_OFF_CTRL, 32'h0600);
    wr(`QPC_OFF_POS, 32'h7);
    enc.pulse();
    rd_chk(`QPC_OFF_POS, 32'h7);
    rd_chk(`QPC_OFF_ISTAT, 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk_bit(rerr, 1'b1);
    chk_word(rd, 32'h0);
    done("index and unmapped");
  endtask

  // With the clock enable low a double step slips past unseen; once
  // awake the synchroniser sees both phases move and drops the step.
  task automatic t_freeze();
    ce <= 1'b0;
    repeat (2) enc.step(1'b1);
    ce <= 1'b1;
    rd_chk(`QPC_OFF_POS, 32'h7);
    done("freeze");
  endtask

  // A natural rollover in an index mode is neither an error nor an event.
  task automatic t_idx_roll();
    wr(`QPC_OFF_ISTAT, 32'h2);
    wr(`QPC_OFF_POS, 32'hFFFF);
    enc.step(1'b1);
    rd_chk(`QPC_OFF_POS, 32'h0);
    rd_chk(`QPC_OFF_ISTAT, 32'h0);
    rd_chk(`QPC_OFF_CTRL, 32'h0E00);
    done("index rollover");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for four cycles, then every scenario in turn.
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_x4();
    t_x2();
    t_err_up();
    t_error_irq_disable();
    t_err_dn();
    t_wrap();
    t_index();
    t_freeze();
    t_idx_roll();
    complete_run();
  end

  // Watchdog: the scenarios need well under a tenth of this span.
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule
